// ==== core/pcia_core.v ====
// Purpose: indirect payload control memories and pattern gen/detector
// Assumes: synchronous microprocessor strobes, active low
// Notes:   one register clock, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "pcia_map.vh"

// What this block does
// - blocks work only while enable bit set
// - busy flag b7 shows pending indirect transfer
// - data 08H then address sets test routing
// - transmit memory has own data/address pair
// - synced when second status read shows sync
// - 08H then 00H injects one bit error
// - writing 00H latches error count into four
// - backplane select routes pattern over backplane
// - standard select picks E1 or T1 set
module pcia_core #(
    parameter XFER_CYCLES = 4,
    parameter PAT_DIV     = 10,
    parameter SYNC_RUN    = 32,
    parameter NUM_CHAN    = 24
) (
    input  wire                clk_i,
    input  wire                rst_i,
    input  wire                cs_n_i,
    input  wire                wr_n_i,
    input  wire                rd_n_i,
    input  wire [10:0]         addr_i,
    input  wire [7:0]          wdata_i,
    output reg  [7:0]          rdata_o,
    output reg                 data_oe_o,
    input  wire                pat_line_i,
    input  wire                pat_bp_i,
    output reg                 pat_line_o,
    output reg                 pat_bp_o,
    output reg  [NUM_CHAN-1:0] rx_test_route_o,
    output reg  [NUM_CHAN-1:0] tx_test_route_o,
    output reg                 pattern_synced_o
);

// ==========================================================
// bus strobes
reg         wr_n_q;
reg         rd_n_q;
reg         standard_select;
wire        wr_edge = !cs_n_i && !wr_n_i && wr_n_q;
wire        rd_edge = !cs_n_i && !rd_n_i && rd_n_q;
wire        rd_act  = !cs_n_i && !rd_n_i;
// framer registers reachable only in the T1/J1 set
wire        t1_set  = standard_select;
wire        wr_t1   = wr_edge && t1_set;

function hit;
    input [10:0] a;
    input [10:0] target;
    begin
        hit = (a == target);
    end
endfunction

// ==========================================================
// control registers
reg  [7:0]  backplane_rx_config;
reg  [7:0]  tx_payload_block_control;
reg  [7:0]  signalling_buffer_control;
reg  [7:0]  rx_payload_block_control;
reg  [7:0]  pattern_error_insert;
reg  [7:0]  tx_ind_addr;
reg  [7:0]  rx_ind_addr;
reg  [7:0]  tx_ind_data;
reg  [7:0]  rx_ind_data;
wire        tx_en = tx_payload_block_control[`PCIA_BLOCK_ENABLE_BIT];
wire        rx_en = rx_payload_block_control[`PCIA_BLOCK_ENABLE_BIT];
wire        bp_sel = backplane_rx_config[`PCIA_BACKPLANE_SEL_BIT];

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        wr_n_q                    <= 1'b1;
        rd_n_q                    <= 1'b1;
        standard_select           <= 1'b0;
        backplane_rx_config       <= `PCIA_ZERO_BYTE;
        tx_payload_block_control  <= `PCIA_ZERO_BYTE;
        signalling_buffer_control <= `PCIA_ZERO_BYTE;
        rx_payload_block_control  <= `PCIA_ZERO_BYTE;
        pattern_error_insert      <= `PCIA_ZERO_BYTE;
    end
    else
    begin
        wr_n_q <= cs_n_i | wr_n_i;
        rd_n_q <= cs_n_i | rd_n_i;
        if (wr_edge && hit(addr_i, `PCIA_GLOBAL_MODE))
            standard_select <= wdata_i[`PCIA_STANDARD_SELECT_BIT];
        if (wr_t1 && hit(addr_i, `PCIA_BACKPLANE_RX_CONFIG))
            backplane_rx_config <= wdata_i;
        if (wr_t1 && hit(addr_i, `PCIA_TX_PAYLOAD_BLOCK_CTRL))
            tx_payload_block_control <= wdata_i;
        if (wr_t1 && hit(addr_i, `PCIA_SIG_BUFFER_CTRL))
            signalling_buffer_control <= wdata_i;
        if (wr_t1 && hit(addr_i, `PCIA_RX_PAYLOAD_BLOCK_CTRL))
            rx_payload_block_control <= wdata_i;
        if (wr_t1 && hit(addr_i, `PCIA_PATTERN_ERROR_INSERT))
            pattern_error_insert <= wdata_i;
    end
end

// ==========================================================
// indirect payload memories
reg  [7:0]  tx_mem [0:127];
reg  [7:0]  rx_mem [0:127];
reg  [7:0]  tx_busy_cnt;
reg  [7:0]  rx_busy_cnt;
wire        tx_busy = (tx_busy_cnt != 8'h00);
wire        rx_busy = (rx_busy_cnt != 8'h00);
wire        tx_done = (tx_busy_cnt == 8'h01);
wire        rx_done = (rx_busy_cnt == 8'h01);
wire [6:0]  tx_chan = tx_ind_addr[`PCIA_CHAN_MSB:`PCIA_CHAN_LSB];
wire [6:0]  rx_chan = rx_ind_addr[`PCIA_CHAN_MSB:`PCIA_CHAN_LSB];
wire        tx_start = wr_t1 && tx_en && !tx_busy &&
                       hit(addr_i, `PCIA_TX_PAYLOAD_IND_ADDR);
wire        rx_start = wr_t1 && rx_en && !rx_busy &&
                       hit(addr_i, `PCIA_RX_PAYLOAD_IND_ADDR);

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        tx_busy_cnt <= 8'h00;
        rx_busy_cnt <= 8'h00;
        tx_ind_addr <= `PCIA_ZERO_BYTE;
        rx_ind_addr <= `PCIA_ZERO_BYTE;
        tx_ind_data <= `PCIA_ZERO_BYTE;
        rx_ind_data <= `PCIA_ZERO_BYTE;
    end
    else
    begin
        // transmit side, own register pair
        if (tx_start)
        begin
            tx_ind_addr <= wdata_i;
            tx_busy_cnt <= XFER_CYCLES[7:0];
        end
        else if (tx_busy)
            tx_busy_cnt <= tx_busy_cnt - 8'h01;
        if (wr_t1 && tx_en && !tx_busy &&
            hit(addr_i, `PCIA_TX_PAYLOAD_IND_DATA))
            tx_ind_data <= wdata_i;
        else if (tx_done && tx_ind_addr[`PCIA_IND_READ_BIT])
            tx_ind_data <= tx_mem[tx_chan];
        // receive side
        if (rx_start)
        begin
            rx_ind_addr <= wdata_i;
            rx_busy_cnt <= XFER_CYCLES[7:0];
        end
        else if (rx_busy)
            rx_busy_cnt <= rx_busy_cnt - 8'h01;
        if (wr_t1 && rx_en && !rx_busy &&
            hit(addr_i, `PCIA_RX_PAYLOAD_IND_DATA))
            rx_ind_data <= wdata_i;
        else if (rx_done && rx_ind_addr[`PCIA_IND_READ_BIT])
            rx_ind_data <= rx_mem[rx_chan];
    end
end

// memory arrays carry no reset; software initialises them
always @(posedge clk_i)
begin
    if (tx_done && !tx_ind_addr[`PCIA_IND_READ_BIT])
        tx_mem[tx_chan] <= tx_ind_data;
    if (rx_done && !rx_ind_addr[`PCIA_IND_READ_BIT])
        rx_mem[rx_chan] <= rx_ind_data;
end

// ==========================================================
// test routing per channel, channel n lives at route bit n-1
reg  [NUM_CHAN-1:0] rx_route_bits;
reg  [NUM_CHAN-1:0] tx_route_bits;
genvar gi;
generate
    for (gi = 0; gi < NUM_CHAN; gi = gi + 1)
    begin : g_route
        always @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                rx_route_bits[gi] <= 1'b0;
                tx_route_bits[gi] <= 1'b0;
            end
            else
            begin
                if (rx_done && !rx_ind_addr[`PCIA_IND_READ_BIT] &&
                    rx_chan == gi + 1)
                    rx_route_bits[gi] <=
                        rx_ind_data[`PCIA_TEST_ROUTE_BIT];
                if (tx_done && !tx_ind_addr[`PCIA_IND_READ_BIT] &&
                    tx_chan == gi + 1)
                    tx_route_bits[gi] <=
                        tx_ind_data[`PCIA_TEST_ROUTE_BIT];
            end
        end
    end
endgenerate

// ==========================================================
// pattern generator with error insertion
reg  [7:0]  div_cnt;
reg         pat_tick;
reg  [14:0] gen_lfsr;
reg         err_pending;
wire        gen_bit = gen_lfsr[14] ^ gen_lfsr[13];
wire        ins_wr  = wr_t1 && hit(addr_i, `PCIA_PATTERN_ERROR_INSERT);
// armed by 08H, fires on the following 00H write
wire        ins_fire = ins_wr && (wdata_i == `PCIA_ZERO_BYTE) &&
                       pattern_error_insert[`PCIA_INSERT_ARM_BIT];

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        div_cnt     <= 8'h00;
        pat_tick    <= 1'b0;
        gen_lfsr    <= `PCIA_PRBS_SEED;
        err_pending <= 1'b0;
        pat_line_o  <= 1'b0;
        pat_bp_o    <= 1'b0;
    end
    else
    begin
        pat_tick <= (div_cnt == PAT_DIV[7:0] - 8'h01);
        if (div_cnt == PAT_DIV[7:0] - 8'h01)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
        if (ins_fire)
            err_pending <= 1'b1;
        else if (pat_tick)
            err_pending <= 1'b0;
        if (pat_tick)
        begin
            gen_lfsr <= {gen_lfsr[13:0], gen_bit};
            pat_line_o <= bp_sel ? 1'b0 : gen_bit ^ err_pending;
            pat_bp_o   <= bp_sel ? gen_bit ^ err_pending : 1'b0;
        end
    end
end

// ==========================================================
// pattern detector
reg  [14:0] det_sr;
reg  [7:0]  match_run;
reg         sync_flag;
reg         bit_error_flag;
reg  [31:0] err_accum;
reg  [31:0] err_latched;
reg         status_read_twice;
wire        det_in   = bp_sel ? pat_bp_i : pat_line_i;
wire        det_miss = pat_tick && (det_in != (det_sr[14] ^ det_sr[13]));
wire        stat_rd  = rd_edge && t1_set &&
                       hit(addr_i, `PCIA_PATTERN_DET_STATUS);
wire        latch_wr = wr_t1 && hit(addr_i, `PCIA_PATTERN_ERROR_COUNT_0)
                       && (wdata_i == `PCIA_LATCH_VALUE);

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        det_sr            <= `PCIA_PRBS_SEED;
        match_run         <= 8'h00;
        sync_flag         <= 1'b0;
        bit_error_flag    <= 1'b0;
        err_accum         <= `PCIA_ERR_CNT_ZERO;
        err_latched       <= `PCIA_ERR_CNT_ZERO;
        status_read_twice <= 1'b0;
        pattern_synced_o  <= 1'b0;
    end
    else
    begin
        if (pat_tick)
            det_sr <= {det_sr[13:0], det_in};
        if (det_miss)
            match_run <= 8'h00;
        else if (pat_tick && match_run != SYNC_RUN[7:0])
            match_run <= match_run + 8'h01;
        if (det_miss)
            sync_flag <= 1'b0;
        else if (match_run == SYNC_RUN[7:0])
            sync_flag <= 1'b1;
        // error flag clears on status read, a new miss wins
        if (det_miss)
            bit_error_flag <= 1'b1;
        else if (stat_rd)
            bit_error_flag <= 1'b0;
        if (latch_wr)
        begin
            err_latched <= err_accum;
            err_accum   <= det_miss ? 32'h0000_0001 : `PCIA_ERR_CNT_ZERO;
        end
        else if (det_miss && sync_flag)
            err_accum <= err_accum + 32'h0000_0001;
        if (stat_rd)
        begin
            status_read_twice <= !status_read_twice;
            if (status_read_twice)
                pattern_synced_o <= sync_flag && !bit_error_flag;
        end
    end
end

// ==========================================================
// read mux
reg  [7:0]  next_rdata;
always @*
begin
    next_rdata = `PCIA_ZERO_BYTE;
    if (hit(addr_i, `PCIA_GLOBAL_MODE))
        next_rdata = {7'h00, standard_select};
    else if (t1_set)
    begin
        case (addr_i)
            `PCIA_BACKPLANE_RX_CONFIG:   next_rdata = backplane_rx_config;
            `PCIA_TX_PAYLOAD_BLOCK_CTRL:
                next_rdata = tx_payload_block_control;
            `PCIA_TX_PAYLOAD_BLOCK_STAT: next_rdata = {tx_busy, 7'h00};
            `PCIA_SIG_BUFFER_CTRL:       next_rdata = signalling_buffer_control;
            `PCIA_SIG_BUFFER_STAT:       next_rdata = 8'h00;
            `PCIA_RX_PAYLOAD_BLOCK_CTRL:
                next_rdata = rx_payload_block_control;
            `PCIA_RX_PAYLOAD_BLOCK_STAT: next_rdata = {rx_busy, 7'h00};
            `PCIA_PATTERN_DET_STATUS:
                next_rdata = {3'h0, sync_flag, 1'b0, bit_error_flag, 2'h0};
            `PCIA_PATTERN_ERROR_INSERT:  next_rdata = pattern_error_insert;
            `PCIA_PATTERN_ERROR_COUNT_0: next_rdata = err_latched[7:0];
            `PCIA_PATTERN_ERROR_COUNT_1: next_rdata = err_latched[15:8];
            `PCIA_PATTERN_ERROR_COUNT_2: next_rdata = err_latched[23:16];
            `PCIA_PATTERN_ERROR_COUNT_3: next_rdata = err_latched[31:24];
            `PCIA_TX_PAYLOAD_IND_ADDR:   next_rdata = tx_ind_addr;
            `PCIA_TX_PAYLOAD_IND_DATA:   next_rdata = tx_ind_data;
            `PCIA_RX_PAYLOAD_IND_ADDR:   next_rdata = rx_ind_addr;
            `PCIA_RX_PAYLOAD_IND_DATA:   next_rdata = rx_ind_data;
            default:                     next_rdata = `PCIA_ZERO_BYTE;
        endcase
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rdata_o         <= `PCIA_ZERO_BYTE;
        data_oe_o       <= 1'b0;
        rx_test_route_o <= {NUM_CHAN{1'b0}};
        tx_test_route_o <= {NUM_CHAN{1'b0}};
    end
    else
    begin
        rdata_o         <= rd_act ? next_rdata : `PCIA_ZERO_BYTE;
        data_oe_o       <= rd_act;
        rx_test_route_o <= rx_en ? rx_route_bits : {NUM_CHAN{1'b0}};
        tx_test_route_o <= tx_en ? tx_route_bits : {NUM_CHAN{1'b0}};
    end
end

endmodule
`default_nettype wire

// ==== core/pcia_map.vh ====
// Purpose: address map, fields and constants of the payload control block
// Assumes: 11-bit register address, 8-bit data
// Notes:   included by pcia_core.v only
`ifndef PCIA_MAP_VH
`define PCIA_MAP_VH
// ==========================================================
// register offsets
`define PCIA_BACKPLANE_RX_CONFIG     11'h00F
`define PCIA_TX_PAYLOAD_BLOCK_CTRL   11'h030
`define PCIA_TX_PAYLOAD_BLOCK_STAT   11'h031
`define PCIA_SIG_BUFFER_CTRL         11'h040
`define PCIA_SIG_BUFFER_STAT         11'h041
`define PCIA_RX_PAYLOAD_BLOCK_CTRL   11'h050
`define PCIA_RX_PAYLOAD_BLOCK_STAT   11'h051
`define PCIA_PATTERN_DET_STATUS      11'h061
`define PCIA_PATTERN_ERROR_INSERT    11'h064
`define PCIA_PATTERN_ERROR_COUNT_0   11'h06C
`define PCIA_PATTERN_ERROR_COUNT_1   11'h06D
`define PCIA_PATTERN_ERROR_COUNT_2   11'h06E
`define PCIA_PATTERN_ERROR_COUNT_3   11'h06F
`define PCIA_TX_PAYLOAD_IND_ADDR     11'h0B2
`define PCIA_TX_PAYLOAD_IND_DATA     11'h0B3
`define PCIA_RX_PAYLOAD_IND_ADDR     11'h0D2
`define PCIA_RX_PAYLOAD_IND_DATA     11'h0D3
`define PCIA_GLOBAL_MODE             11'h400
// ==========================================================
// field positions
`define PCIA_BLOCK_ENABLE_BIT        0
`define PCIA_BUSY_BIT                7
`define PCIA_SYNC_FLAG_BIT           4
`define PCIA_BIT_ERROR_FLAG_BIT      2
`define PCIA_BACKPLANE_SEL_BIT       2
`define PCIA_STANDARD_SELECT_BIT     0
`define PCIA_TEST_ROUTE_BIT          3
`define PCIA_INSERT_ARM_BIT          3
`define PCIA_IND_READ_BIT            7
// ==========================================================
// values and reset values
`define PCIA_ZERO_BYTE               8'h00
`define PCIA_LATCH_VALUE             8'h00
`define PCIA_CHAN_LSB                0
`define PCIA_CHAN_MSB                6
`define PCIA_PRBS_SEED               15'h7FFF
`define PCIA_ERR_CNT_ZERO            32'h0000_0000
`endif

// ==== tb/pcia_checker.sv ====
// Purpose: port-level checks of the payload control block
// Assumes: bound to pcia_core, one register clock
// Notes:   mode and block writes are tracked from taken strobes
`timescale 1ns/10ps
`default_nettype none
module pcia_checker #(
    parameter NUM_CHAN = 24
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                cs_n_i,
    input wire logic                wr_n_i,
    input wire logic                rd_n_i,
    input wire logic [10:0]         addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                data_oe_o,
    input wire logic                pat_line_i,
    input wire logic                pat_bp_i,
    input wire logic                pat_line_o,
    input wire logic                pat_bp_o,
    input wire logic [NUM_CHAN-1:0] rx_test_route_o,
    input wire logic [NUM_CHAN-1:0] tx_test_route_o,
    input wire logic                pattern_synced_o
);
    // ==========================================================
    // helper logic
    logic       wr_q;
    logic       rd_q;
    logic       mode;
    logic [3:0] rx_age;
    logic [3:0] tx_age;
    logic [1:0] sy_age;
    wire wr_go = !cs_n_i && !wr_n_i && wr_q;
    wire rd_go = !cs_n_i && !rd_n_i && rd_q;
    wire w_rx = wr_go && mode && (addr_i == 11'h050 || addr_i == 11'h0d2);
    wire w_tx = wr_go && mode && (addr_i == 11'h030 || addr_i == 11'h0b2);
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q   <= 1'b1;
            rd_q   <= 1'b1;
            mode   <= 1'b0;
            rx_age <= 4'hf;
            tx_age <= 4'hf;
            sy_age <= 2'h3;
        end
        else
        begin
            wr_q   <= cs_n_i | wr_n_i;
            rd_q   <= cs_n_i | rd_n_i;
            if (wr_go && addr_i == 11'h400)
                mode <= wdata_i[0];
            rx_age <= w_rx ? 4'h0 : rx_age + {3'h0, rx_age != 4'hf};
            tx_age <= w_tx ? 4'h0 : tx_age + {3'h0, tx_age != 4'hf};
            sy_age <= (rd_go && mode && addr_i == 11'h061) ? 2'h0 :
                      sy_age + {1'b0, sy_age != 2'h3};
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_oe_read;
        data_oe_o == $past(!cs_n_i && !rd_n_i);
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("read enable not one cycle after strobe");
    property p_rdata_idle;
        !data_oe_o |-> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero while idle");
    property p_e1_hidden;
        (!cs_n_i && !rd_n_i && !mode && addr_i != 11'h400)
            |=> rdata_o == 8'h00;
    endproperty
    a_e1_hidden: assert property (p_e1_hidden)
        else $error("register visible with standard select low");
    property p_rx_off;
        (wr_go && mode && addr_i == 11'h050 && !wdata_i[0])
            |-> ##2 rx_test_route_o == {NUM_CHAN{1'b0}};
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("rx routing kept while disabled");
    property p_tx_off;
        (wr_go && mode && addr_i == 11'h030 && !wdata_i[0])
            |-> ##2 tx_test_route_o == {NUM_CHAN{1'b0}};
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("tx routing kept while disabled");
    property p_rx_cause;
        (rx_test_route_o & ~$past(rx_test_route_o)) != 0 |-> rx_age <= 4'h8;
    endproperty
    a_rx_cause: assert property (p_rx_cause)
        else $error("rx routing set without address write");
    property p_tx_cause;
        (tx_test_route_o & ~$past(tx_test_route_o)) != 0 |-> tx_age <= 4'h8;
    endproperty
    a_tx_cause: assert property (p_tx_cause)
        else $error("tx routing set without address write");
    property p_sync_cause;
        $changed(pattern_synced_o) |-> sy_age <= 2'h2;
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("sync result changed without status read");
    property p_gen_tick;
        $changed(pat_line_o) |=> $stable(pat_line_o);
    endproperty
    a_gen_tick: assert property (p_gen_tick)
        else $error("generator changed on adjacent cycles");
    c_rx_write: cover property (w_rx);
    c_synced: cover property ($rose(pattern_synced_o));
    c_read: cover property (data_oe_o);
endmodule
bind pcia_core pcia_checker #(.NUM_CHAN(NUM_CHAN)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i),
    .rd_n_i(rd_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .data_oe_o(data_oe_o), .pat_line_i(pat_line_i),
    .pat_bp_i(pat_bp_i), .pat_line_o(pat_line_o), .pat_bp_o(pat_bp_o),
    .rx_test_route_o(rx_test_route_o), .tx_test_route_o(tx_test_route_o),
    .pattern_synced_o(pattern_synced_o)
);
`default_nettype wire

// ==== tb/pcia_loop.sv ====
// Purpose: far-end loopback of line and backplane pattern paths
// Assumes: one register of delay each way
// Notes:   a cut line idles at mark level instead of the data
`timescale 1ns/10ps
`default_nettype none
module pcia_loop (
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic bp_i,
    input  wire logic cut_line_i,
    output var  logic line_o,
    output var  logic bp_o
);
    // a cut line floats to its pull-up: all ones, never a valid pattern
    always @(posedge clk_i)
    begin
        line_o <= cut_line_i ? 1'b1 : line_i;
        bp_o   <= bp_i;
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: register-level tests of the payload control block
// Assumes: strobes driven on the falling clock edge
// Notes:   pattern ticks shortened to two clocks
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cs_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        cut = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic [7:0]  s;
    logic [23:0] rx;
    logic [23:0] tx;
    logic        lo;
    logic        bo;
    logic        li;
    logic        bi;
    logic        syn;
    int          err_count = 0;
    int          compares = 0;
    initial forever #25 clk_i = ~clk_i;
    pcia_core #(.PAT_DIV(2)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
        .rd_n_i(rd_n), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .data_oe_o(), .pat_line_i(li), .pat_bp_i(bi), .pat_line_o(lo),
        .pat_bp_o(bo), .rx_test_route_o(rx), .tx_test_route_o(tx),
        .pattern_synced_o(syn)
    );
    pcia_loop i_loop (
        .clk_i(clk_i), .line_i(lo), .bp_i(bo), .cut_line_i(cut),
        .line_o(li), .bp_o(bi)
    );
    // ==========================================================
    // access tasks
    task automatic chk(input logic [47:0] v, input logic [47:0] e,
                       input string n);
        compares++;
        if (v !== e)
        begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, v);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {cs_n, wr_n, addr, wdata} = {2'b00, a, d};
        @(negedge clk_i);
        {cs_n, wr_n} = 2'b11;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {cs_n, rd_n, addr} = {2'b00, a};
        @(negedge clk_i);
        d = rdata;
        {cs_n, rd_n} = 2'b11;
    endtask
    task automatic idle(input logic [10:0] a);
        logic [7:0] v;
        int n;
        v = 8'hff;
        n = 0;
        while (v[7] !== 1'b0 && n < 20)
        begin
            rd(a, v);
            n++;
        end
        chk(v[7], 1'b0, "busy");
    endtask
    task automatic ind(input bit t, input logic [7:0] d, input logic [7:0] c);
        wr(t ? 11'h0b3 : 11'h0d3, d);
        wr(t ? 11'h0b2 : 11'h0d2, c);
        idle(t ? 11'h031 : 11'h051);
    endtask
    task automatic cnt(input logic [31:0] e);
        logic [31:0] v;
        wr(11'h06c, 8'h00);
        for (int i = 0; i < 4; i++)
            rd(11'h06c + 11'(i), v[8*i +: 8]);
        chk(v, e, "error count");
    endtask
    task automatic sync(input logic e);
        repeat (400) @(negedge clk_i);
        rd(11'h061, s);
        rd(11'h061, s);
        @(negedge clk_i);
        chk(syn, e, "synced");
        chk(s[4], e, "sync flag");
    endtask
    task automatic close_out;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial
    begin
        #1_000_000;
        err_count++;
        close_out;
    end
    initial
    begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        chk(rx, 0, "reset rx routes");
        chk(tx, 0, "reset tx routes");
        chk(syn, 0, "reset synced");
        wr(11'h050, 8'h01);
        rd(11'h050, s);
        chk(s, 8'h00, "hidden reg");
        wr(11'h400, 8'h01);
        rd(11'h400, s);
        chk(s, 8'h01, "standard select");
        wr(11'h0d3, 8'h08);
        wr(11'h0d2, 8'h02);
        repeat (8) @(negedge clk_i);
        chk(rx, 0, "disabled write");
        foreach (s[i]) wr(11'h030 + 11'(i[0]) * 11'h010 + 11'(i[1]) * 11'h020,
                          8'h01);
        rd(11'h050, s);
        chk(s, 8'h01, "rx enable");
        rd(11'h041, s);
        chk(s, 8'h00, "sig status");
        for (int c = 1; c <= 24; c++)
        begin
            ind(1'b0, 8'h00, 8'(c));
            ind(1'b1, 8'h00, 8'(c));
        end
        chk({rx, tx}, 0, "cleared");
        wr(11'h0d3, 8'h08);
        wr(11'h0d2, 8'h02);
        rd(11'h051, s);
        chk(s[7], 1'b1, "busy set");
        idle(11'h051);
        ind(1'b0, 8'h08, 8'h04);
        ind(1'b0, 8'h08, 8'h05);
        ind(1'b1, 8'h08, 8'h02);
        ind(1'b1, 8'h08, 8'h04);
        ind(1'b1, 8'h08, 8'h05);
        repeat (4) @(negedge clk_i);
        chk(rx, 24'h00_001a, "rx routes");
        chk(tx, 24'h00_001a, "tx routes");
        ind(1'b0, 8'h00, 8'h82);
        rd(11'h0d3, s);
        chk(s, 8'h08, "rx entry");
        ind(1'b0, 8'h08, 8'h83);
        rd(11'h0d3, s);
        chk(s, 8'h00, "rx clear entry");
        ind(1'b1, 8'h00, 8'h84);
        rd(11'h0b3, s);
        chk(s, 8'h08, "tx entry");
        wr(11'h050, 8'h00);
        repeat (3) @(negedge clk_i);
        chk({rx, tx}, {24'h0, 24'h00_001a}, "rx off");
        wr(11'h050, 8'h01);
        wr(11'h030, 8'h00);
        repeat (3) @(negedge clk_i);
        chk(rx, 24'h00_001a, "rx back");
        chk(tx, 0, "tx off");
        wr(11'h030, 8'h01);
        repeat (3) @(negedge clk_i);
        chk(tx, 24'h00_001a, "tx back");
        sync(1'b1);
        chk(s[2], 1'b0, "no bit error");
        cnt(0);
        repeat (3)
        begin
            wr(11'h064, 8'h08);
            wr(11'h064, 8'h00);
            repeat (300) @(negedge clk_i);
        end
        cnt(3);
        cut = 1'b1;
        wr(11'h00f, 8'h04);
        rd(11'h00f, s);
        chk(s, 8'h04, "backplane select");
        sync(1'b1);
        wr(11'h00f, 8'h00);
        sync(1'b0);
        close_out;
    end
endmodule
`default_nettype wire
